// ---- core/isp_port.v ----
// Serial register port of a six-axis inertial sensor
`timescale 1ns/1ps
`default_nettype none
`include "isp_consts.vh"
module isp_port #(
    parameter SMPL_CYC   = `ISP_SMPL_CYC,
    parameter BACKUP_CYC = `ISP_BACKUP_CYC
) (
    // Clock, reset, enable
    input  wire        core_clk,
    input  wire        rst_n,
    input  wire        clk_en,
    // Serial pins
    input  wire        sclk,
    input  wire        cs_n,
    input  wire        din,
    output reg         dout_r,
    // Sensor results, loaded each sample
    input  wire [175:0] sens_data,
    // Status and events
    output reg         data_ready_pin_r,
    output reg         backup_busy_r,
    output reg  [15:0] sample_period_setting_r
);
    // RL15: host drives clock and select
    // Two-stage synchronisers
    reg [1:0] sclk_s_r, cs_s_r, din_s_r;
    reg       sclk_d_r;
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sclk_s_r <= 2'h3;
            cs_s_r   <= 2'h3;
            din_s_r  <= 2'h0;
            sclk_d_r <= 1'b1;
        end else if (clk_en) begin
            sclk_s_r <= {sclk_s_r[0], sclk};
            cs_s_r   <= {cs_s_r[0], cs_n};
            din_s_r  <= {din_s_r[0], din};
            sclk_d_r <= sclk_s_r[1];
        end
    end
    wire sclk_q = sclk_s_r[1];
    wire cs_q   = cs_s_r[1];
    // RL3: mode 3 edges
    wire rise   = !cs_q && sclk_q && !sclk_d_r;
    wire fall   = !cs_q && !sclk_q && sclk_d_r;

    reg [15:0] rx_r, tx_r;
    reg [4:0]  bits_r;
    reg        cs_d_r;
    reg [5:0]  rd_idx_r;
    reg [15:0] flash_write_counter_r;
    reg [31:0] smpl_cnt_r;
    reg [31:0] bk_cnt_r;
    reg [3:0]  ld_idx_r;
    reg        ld_st_r;
    reg        pending_r;
    reg [1:0]  boot_st_r;
    reg        wp_r;
    reg [5:0]  wp_addr_r;
    reg [1:0]  wp_be_r;
    reg [7:0]  wp_byte_r;
    reg [15:0] ans_nxt;
    reg        mw_en;
    reg [5:0]  mw_addr;
    reg [1:0]  mw_be;
    reg [15:0] mw_data;

    // Loader and boot states
    localparam LD_IDLE   = 1'b0;
    localparam LD_RUN    = 1'b1;
    localparam LD_LAST   = 4'hA;
    localparam BOOT_MSC  = 2'h0;
    localparam BOOT_SENS = 2'h1;
    localparam BOOT_DONE = 2'h2;
    wire       ld_busy   = (ld_st_r == LD_RUN);
    wire       boot_done = (boot_st_r == BOOT_DONE);

    wire        frame_end = cs_q && !cs_d_r && (bits_r == 5'd16);
    wire [5:0]  waddr     = rx_r[14:9];
    // RL8: byte lane from address bit zero
    wire        whi       = rx_r[8];
    // RL17: only writable addresses accepted
    wire        w_ok      = (waddr >= `ISP_A_RW_FIRST) && (waddr <= `ISP_A_RW_LAST)
                            && (waddr != 6'h1D);
    wire        is_glob   = (waddr == `ISP_A_GLOBAL_COMMAND_REG);
    // RL12: write at frame end
    wire        do_wr     = frame_end && rx_r[15] && w_ok;
    // RL13: command bit three of the command word
    wire        bk_start  = frame_end && rx_r[15] && is_glob && !whi
                            && rx_r[`ISP_GLOB_BACKUP];
    wire        prd_wr    = frame_end && rx_r[15] && (waddr == `ISP_A_SAMPLE_PERIOD_SETTING);
    wire [15:0] mem_rd;

    // Loader owns the port, so the sample period never jitters
    always @* begin
        mw_en   = 1'b0;
        mw_addr = 6'h00;
        mw_be   = 2'h0;
        mw_data = 16'h0000;
        if (boot_st_r == BOOT_MSC) begin
            mw_en   = 1'b1;
            mw_addr = `ISP_A_MSC;
            mw_be   = 2'h3;
            mw_data = `ISP_MSC_RST;
        end else if (boot_st_r == BOOT_SENS) begin
            mw_en   = 1'b1;
            mw_addr = `ISP_A_SENS;
            mw_be   = 2'h3;
            mw_data = `ISP_SENS_RST;
        end else if (ld_busy) begin
            mw_en   = 1'b1;
            mw_addr = {2'h0, ld_idx_r} + `ISP_A_OUT_FIRST;
            mw_be   = 2'h3;
            mw_data = sens_data[ld_idx_r*16 +: 16];
        end else if (wp_r) begin
            mw_en   = 1'b1;
            mw_addr = wp_addr_r;
            mw_be   = wp_be_r;
            mw_data = {wp_byte_r, wp_byte_r};
        end
    end

    // Boot defaults, then staged frame writes
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            boot_st_r <= BOOT_MSC;
            wp_r      <= 1'b0;
            wp_addr_r <= 6'h00;
            wp_be_r   <= 2'h0;
            wp_byte_r <= 8'h00;
        end else if (clk_en) begin
            case (boot_st_r)
                BOOT_MSC:  boot_st_r <= BOOT_SENS;
                BOOT_SENS: boot_st_r <= BOOT_DONE;
                default:   boot_st_r <= BOOT_DONE;
            endcase
            // RL12: frame write waits at most one load
            if (do_wr) begin
                wp_r      <= 1'b1;
                wp_addr_r <= waddr;
                wp_be_r   <= whi ? 2'h2 : 2'h1;
                wp_byte_r <= rx_r[7:0];
            end else if (wp_r && boot_done && !ld_busy) begin
                wp_r <= 1'b0;
            end
        end
    end

    // Answer for the next frame
    always @* begin
        case (rd_idx_r)
            `ISP_A_FLASH_WRITE_COUNTER: ans_nxt = flash_write_counter_r;
            `ISP_A_SAMPLE_PERIOD_SETTING:  ans_nxt = sample_period_setting_r;
            default:          ans_nxt = mem_rd;
        endcase
    end

    isp_regfile #(.AW(6)) u_mem (
        .core_clk  (core_clk),
        .rst_n     (rst_n),
        .clk_en    (clk_en),
        .wr_en     (mw_en),
        .wr_addr   (mw_addr),
        .wr_be     (mw_be),
        .wr_data   (mw_data),
        .rd_addr   (rd_idx_r),
        .rd_data_r (mem_rd)
    );

    // Frame shifter
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_r     <= 16'h0000;
            tx_r     <= 16'h0000;
            bits_r   <= 5'd0;
            cs_d_r   <= 1'b1;
            dout_r   <= 1'b0;
            rd_idx_r <= 6'h00;
        end else if (clk_en) begin
            cs_d_r <= cs_q;
            if (cs_q) begin
                bits_r <= 5'd0;
            end else if (rise) begin
                // RL6: sample on rising edge
                // RL4: MSB first into shifter
                rx_r   <= {rx_r[14:0], din_s_r[1]};
                bits_r <= bits_r + 5'd1;
            end else if (fall && bits_r != 5'd0) begin
                // RL5: shift out on falling edge
                dout_r <= tx_r[15];
                tx_r   <= {tx_r[14:0], 1'b0};
            end
            if (!cs_q && cs_d_r) begin
                // RL10: first bit ready before first falling edge
                dout_r <= tx_r[15];
                tx_r   <= {tx_r[14:0], 1'b0};
            end
            if (frame_end && !rx_r[15]) begin
                // RL9: latch read address
                rd_idx_r <= rx_r[14:9];
            end
            // RL11: next answer loaded while idle
            if (cs_q && cs_d_r) begin
                tx_r <= ans_nxt;
            end
        end
    end

    // RL2: free-running sample timer
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            smpl_cnt_r <= 32'h0;
        end else if (clk_en) begin
            if (smpl_cnt_r >= SMPL_CYC - 1) begin
                smpl_cnt_r <= 32'h0;
            end else begin
                smpl_cnt_r <= smpl_cnt_r + 32'h1;
            end
        end
    end
    wire smpl_tick = (smpl_cnt_r >= SMPL_CYC - 1);

    // Load sequencer
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ld_st_r          <= LD_IDLE;
            ld_idx_r         <= 4'h0;
            data_ready_pin_r <= 1'b0;
            pending_r        <= 1'b0;
        end else if (clk_en) begin
            data_ready_pin_r <= 1'b0;
            case (ld_st_r)
                LD_IDLE: begin
                    if (pending_r && boot_done) begin
                        ld_st_r   <= LD_RUN;
                        ld_idx_r  <= 4'h0;
                        pending_r <= 1'b0;
                    end
                end
                LD_RUN: begin
                    if (ld_idx_r == LD_LAST) begin
                        ld_st_r          <= LD_IDLE;
                        // RL1: pulse after all outputs loaded
                        data_ready_pin_r <= 1'b1;
                    end else begin
                        ld_idx_r <= ld_idx_r + 4'h1;
                    end
                end
                default: ld_st_r <= LD_IDLE;
            endcase
            // A tick beats the clear above
            if (smpl_tick) begin
                pending_r <= 1'b1;
            end
        end
    end

    // Sample period register and flash backup
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sample_period_setting_r <= `ISP_SAMPLE_PERIOD_SETTING_RST;
            flash_write_counter_r   <= 16'h0000;
            backup_busy_r           <= 1'b0;
            bk_cnt_r                <= 32'd0;
        end else if (clk_en) begin
            if (prd_wr) begin
                if (whi) begin
                    sample_period_setting_r[15:8] <= rx_r[7:0];
                end else begin
                    sample_period_setting_r[7:0] <= rx_r[7:0];
                end
            end
            // RL13: backup command bit
            if (bk_start && !backup_busy_r) begin
                backup_busy_r <= 1'b1;
                bk_cnt_r      <= 32'd0;
            end else if (backup_busy_r) begin
                if (bk_cnt_r >= BACKUP_CYC - 1) begin
                    backup_busy_r <= 1'b0;
                    // RL14: count completed backups
                    flash_write_counter_r <= flash_write_counter_r + 16'h0001;
                end else begin
                    bk_cnt_r <= bk_cnt_r + 32'd1;
                end
            end
        end
    end
endmodule
`default_nettype wire

// ---- core/isp_consts.vh ----
// Constants for the inertial sensor serial port
// Operation
// RL1: Load outputs, then pulse data ready
// RL2: Sample autonomously at 819.2 SPS after reset
// RL3: SPI mode 3, clock idles high
// RL4: 16-bit frames, MSB first, chip select low
// RL5: Output changes on falling clock edge
// RL6: Input sampled on rising clock edge
// RL7: Host keeps clock within rate limits
// RL8: Each register has two byte addresses
// RL9: Read request: top bit clear, address
// RL10: Addressed register returned in next frame
// RL11: Full duplex: next command during return
// RL12: Write frame loads byte at frame end
// RL13: Command bit three starts 50 ms backup
// RL14: Backup increments flash write counter
// RL15: Device is slave only
// RL16: Host leaves stall time between frames
// RL17: Writes to read-only addresses ignored
`ifndef ISP_CONSTS_VH
`define ISP_CONSTS_VH
`define ISP_CLK_HZ         250000000
`define ISP_SPS_X10        8192
`define ISP_SMPL_CYC       ((`ISP_CLK_HZ * 5) / (`ISP_SPS_X10 / 2))
`define ISP_BACKUP_MS      50
`define ISP_BACKUP_CYC     ((`ISP_CLK_HZ / 1000) * `ISP_BACKUP_MS)
`define ISP_FRAME_BITS     16
`define ISP_A_FLASH_WRITE_COUNTER    6'h00
`define ISP_A_OUT_FIRST    6'h01
`define ISP_A_OUT_LAST     6'h0B
`define ISP_A_RW_FIRST     6'h0D
`define ISP_A_RW_LAST      6'h1D
`define ISP_A_SAMPLE_PERIOD_SETTING     6'h1B
`define ISP_A_GLOBAL_COMMAND_REG     6'h1F
`define ISP_GLOB_BACKUP    3
`define ISP_SAMPLE_PERIOD_SETTING_RST   16'h0001
`define ISP_MSC_RST        16'h0006
`define ISP_SENS_RST       16'h0402
`define ISP_A_MSC          6'h1A
`define ISP_A_SENS         6'h1C
`endif

// ---- core/isp_regfile.v ----
// Register memory for the inertial sensor serial port
`timescale 1ns/1ps
`default_nettype none
module isp_regfile #(
    parameter AW = 6
) (
    // Clock and reset
    input  wire          core_clk,
    input  wire          rst_n,
    input  wire          clk_en,
    // Write port, byte lanes
    input  wire          wr_en,
    input  wire [AW-1:0] wr_addr,
    input  wire [1:0]    wr_be,
    input  wire [15:0]   wr_data,
    // Read port
    input  wire [AW-1:0] rd_addr,
    output reg  [15:0]   rd_data_r
);
    reg [15:0] mem_r [0:(1<<AW)-1];
    integer i;
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (i = 0; i < (1<<AW); i = i + 1) begin
                mem_r[i] <= 16'h0000;
            end
            rd_data_r <= 16'h0000;
        end else if (clk_en) begin
            if (wr_en) begin
                if (wr_be[0]) begin
                    mem_r[wr_addr][7:0] <= wr_data[7:0];
                end
                if (wr_be[1]) begin
                    mem_r[wr_addr][15:8] <= wr_data[15:8];
                end
            end
            rd_data_r <= mem_r[rd_addr];
        end
    end
endmodule
`default_nettype wire

// ---- test/isp_port_monitor.sv ----
// Assertion checker for the serial port
`timescale 1ns/1ps
`default_nettype none
module isp_mon #(
    parameter int SMPL_CYC   = 200,
    parameter int BACKUP_CYC = 50
) (
    // Clock and reset
    input wire logic        core_clk,
    input wire logic        rst_n,
    input wire logic        clk_en,
    // Serial pins
    input wire logic        sclk,
    input wire logic        cs_n,
    input wire logic        dout_r,
    // Status
    input wire logic        data_ready_pin_r,
    input wire logic        backup_busy_r,
    input wire logic [15:0] sample_period_setting_r
);
    default clocking @(posedge core_clk); endclocking
    // Frozen cycles are not counted
    default disable iff (!rst_n || !clk_en);
    logic [31:0] gap_r;
    logic [31:0] bsy_r;
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            gap_r <= 32'h0;
            bsy_r <= 32'h0;
        end else if (clk_en) begin
            gap_r <= data_ready_pin_r ? 32'h0 : gap_r + 32'h1;
            bsy_r <= backup_busy_r ? bsy_r + 32'h1 : 32'h0;
        end
    end
    sequence busy_hold;
        backup_busy_r [*8];
    endsequence
    a_ready_one_cycle: assert property (data_ready_pin_r |=> !data_ready_pin_r)
        else $error("data ready wider than one cycle");
    // First gap allows for storing all words
    a_ready_period_max: assert property (gap_r <= SMPL_CYC + 16)
        else $error("sample pulse late");
    a_ready_period_min: assert property (data_ready_pin_r |-> gap_r >= SMPL_CYC - 1)
        else $error("sample pulse early");
    a_dout_on_fall: assert property (!cs_n && !$past(cs_n, 6) && $changed(dout_r) |-> !sclk)
        else $error("dout moved outside clock low phase");
    a_period_reset: assert property ($rose(rst_n) |-> sample_period_setting_r == 16'h0001)
        else $error("period setting not at default");
    a_period_frame_end: assert property ($changed(sample_period_setting_r) |-> cs_n)
        else $error("period setting changed inside frame");
    a_backup_start: assert property ($rose(backup_busy_r) |-> cs_n ##0 busy_hold)
        else $error("backup start wrong");
    a_backup_length: assert property ($fell(backup_busy_r) |-> bsy_r == BACKUP_CYC)
        else $error("backup length wrong");
endmodule
bind isp_port isp_mon #(.SMPL_CYC(SMPL_CYC), .BACKUP_CYC(BACKUP_CYC)) u_mon (
    .core_clk, .rst_n, .clk_en, .sclk, .cs_n, .dout_r, .data_ready_pin_r, .backup_busy_r,
    .sample_period_setting_r);
`default_nettype wire

// ---- test/isp_host_model.sv ----
// Host model: mode 3 serial master
`timescale 1ns/1ps
`default_nettype none
module isp_host_model (
    // Timing reference
    input  wire logic core_clk,
    // Serial pins
    input  wire logic dout,
    output var  logic sclk,
    output var  logic cs_n,
    output var  logic din
);
    initial begin
        sclk = 1'b1;
        cs_n = 1'b1;
        din  = 1'b0;
    end
    task automatic step(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    // master frames 16 bits, MSB first
    task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
        cs_n = 1'b0;
        step(10);
        for (int i = 15; i >= 0; i--) begin
            sclk = 1'b0;
            din  = tx[i];
            step(10);
            rx   = {rx[14:0], dout};
            sclk = 1'b1;
            step(10);
        end
        cs_n = 1'b1;
        // Released line must not look stable
        din  = ~din;
        step(2250);
    endtask
endmodule
`default_nettype wire

// ---- test/tb_top.sv ----
// Self-checking bench for the serial port
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic         core_clk, rst_n, sclk, cs_n, din, dout_r, rdy, busy, en;
    logic [15:0]  frz_hits;
    logic [175:0] sens_data;
    logic [15:0]  period, rx, busy_n;
    int           error_cnt, n_checks, cyc;
    // Command, expected reply to the previous frame, check flag
    logic [32:0]  rows [12] = '{
        {16'h3600, 16'h0000, 1'b0},
        {16'h3700, 16'h0001, 1'b1}, // Default read
        {16'hB605, 16'h0001, 1'b1}, // Upper address
        {16'hB700, 16'h0000, 1'b0}, // Upper write
        {16'h3600, 16'h0000, 1'b0},
        {16'h9812, 16'h0005, 1'b1}, // Written word
        {16'h1800, 16'h0000, 1'b0},
        {16'h0400, 16'h0000, 1'b1}, // Ignored write
        {16'h1600, 16'hA001, 1'b1}, // Sample loaded
        {16'h0000, 16'hA00A, 1'b1}, // Last word
        {16'hA11F, 16'h0000, 1'b1}, // Counter zero
        {16'h2000, 16'h0000, 1'b0}
    };
    isp_port #(.SMPL_CYC(200), .BACKUP_CYC(50)) dut (
        .core_clk(core_clk), .rst_n(rst_n), .clk_en(en), .sclk(sclk), .cs_n(cs_n),
        .din(din), .dout_r(dout_r), .sens_data(sens_data), .data_ready_pin_r(rdy),
        .backup_busy_r(busy), .sample_period_setting_r(period));
    isp_host_model host (.core_clk(core_clk), .dout(dout_r), .sclk(sclk), .cs_n(cs_n), .din(din));
    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cyc++;
        busy_n <= busy_n + {15'h0000, busy};
        if (cyc == 60000) begin
            error_cnt++;
            test_done();
        end
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic test_done();
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    initial begin
        rst_n = 1'b0;
        en = 1'b1;
        frz_hits = 16'h0000;
        error_cnt = 0;
        n_checks = 0;
        cyc = 0;
        busy_n = 16'h0000;
        for (int k = 0; k < 11; k++) sens_data[16*k +: 16] = 16'hA000 + k[15:0];
        repeat (3) @(posedge core_clk);
        #1 rst_n = 1'b1;
        host.step(3);
        for (int r = 0; r < 12; r++) begin
            host.xfer(rows[r][32:17], rx);
            if (rows[r][0]) chk(rx, rows[r][16:1]);
        end
        host.xfer(16'hBE08, rx);
        chk(rx, 16'h1F00);
        chk(busy_n, 16'h0032);
        chk(period, 16'h0005);
        host.xfer(16'h0000, rx);
        host.xfer(16'h0000, rx);
        chk(rx, 16'h0001);
        // Enable low: no sample may complete
        @(posedge core_clk iff rdy);
        host.step(1);
        en = 1'b0;
        repeat (400) begin
            @(posedge core_clk);
            if (rdy) frz_hits++;
        end
        #1 en = 1'b1;
        chk(frz_hits, 16'h0000);
        repeat (250) begin
            @(posedge core_clk);
            if (rdy) frz_hits++;
        end
        chk(frz_hits, 16'h0001);
        #1 rst_n = 1'b0;
        @(posedge core_clk);
        chk(period, 16'h0001);
        test_done();
    end
endmodule
`default_nettype wire
